// [logic/epsc_pkg.sv]
/*
  constants and carrier types for the encoder position sync counter.
  assumes a single 250 mhz control clock and a register port that
  answers reads one cycle after the read strobe.
*/
// Operation
// [R1] encoder pulses count up; control word bits 9 to 11 steer the preset.
// [R2] sync is armed only with inhibit 0, no fault and done-clear 0.
// [R3] armed, a trigger rise loads both preset halves; counting goes on.
// [R4] a controlled preset sets the done flag, held like a set-reset latch.
// [R5] the controller raises done-clear after positioning; done then resets.
// [R6] the controller resets both latches before another synchronisation.
// [R7] the controller triggers by setting control word bit 9, the value 512.
// [R8] control bit 10 is the sync inhibit, bit 11 done-clear; both is 3072.
// [R9] done is status bit 5; count and preset read as 16-bit halves.
package epsc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
  localparam logic [3:0] ADDR_PRE_LO   = 4'h4;
  localparam logic [3:0] ADDR_PRE_HI   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_TRIG      = 9;
  localparam int          BIT_INHIBIT   = 10;
  localparam int          BIT_DONE_CLR  = 11;
  localparam int          BIT_DONE      = 5;
  localparam int          BIT_ARMED     = 0;
  localparam int          BIT_FAULT     = 1;
  localparam int          IRQ_SYNC      = 0;
  localparam int          IRQ_WRAP      = 1;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] PRESET_RESET  = 16'h0000;
  localparam logic [1:0]  MASK_RESET    = 2'h0;
  localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } epsc_bus_t;

  typedef struct packed {
    logic trig;
    logic inhibit;
    logic done_clr;
  } epsc_ctrl_t;

endpackage

// [logic/epsc_counter.sv]
/*
  encoder position counter with armed, edge-triggered preset.
  assumes the encoder pulse and fault inputs are asynchronous pins;
  each pulse is a level high for at least three clocks.
*/
// Our own choices: the address-and-strobe port and the register offsets.
module epsc_counter
  import epsc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire epsc_bus_t         bus_i,
  input  wire logic              enc_pulse_i,
  input  wire logic              fault_i,
  output logic        [15:0]     rdata_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a change counts only once stages two and three agree
  logic [2:0] enc_sync;
  logic [2:0] flt_sync;
  logic       enc_level;
  logic       flt_level;
  logic       next_enc_level;
  logic       next_flt_level;

  always_comb begin
    next_enc_level = enc_level;
    next_flt_level = flt_level;
    if (enc_sync[1] == enc_sync[2]) begin
      next_enc_level = enc_sync[2];
    end
    if (flt_sync[1] == flt_sync[2]) begin
      next_flt_level = flt_sync[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enc_sync  <= 3'h0;
      flt_sync  <= 3'h0;
      enc_level <= 1'b0;
      flt_level <= 1'b0;
    end else begin
      enc_sync  <= {enc_sync[1:0], enc_pulse_i};
      flt_sync  <= {flt_sync[1:0], fault_i};
      enc_level <= next_enc_level;
      flt_level <= next_flt_level;
    end
  end

  // ----------------------------------------------------------------
  // control word and preset halves
  // ----------------------------------------------------------------
  logic [15:0] ctrl_word;
  logic [15:0] preset_lo;
  logic [15:0] preset_hi;
  logic [1:0]  irq_mask;
  logic [15:0] next_ctrl_word;
  logic [15:0] next_preset_lo;
  logic [15:0] next_preset_hi;
  logic [1:0]  next_irq_mask;
  epsc_ctrl_t  ctrl;

  function automatic logic is_wr(input epsc_bus_t b, input logic [3:0] a);
    is_wr = b.wr && (b.addr == a);
  endfunction

  always_comb begin
    next_ctrl_word = ctrl_word;
    next_preset_lo = preset_lo;
    next_preset_hi = preset_hi;
    next_irq_mask  = irq_mask;
    if (is_wr(bus_i, ADDR_CTRL)) begin
      next_ctrl_word = bus_i.wdata;
    end
    if (is_wr(bus_i, ADDR_PRE_LO)) begin
      next_preset_lo = bus_i.wdata;
    end
    if (is_wr(bus_i, ADDR_PRE_HI)) begin
      next_preset_hi = bus_i.wdata;
    end
    if (is_wr(bus_i, ADDR_IRQ_MASK)) begin
      next_irq_mask = bus_i.wdata[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_word <= CTRL_RESET;
      preset_lo <= PRESET_RESET;
      preset_hi <= PRESET_RESET;
      irq_mask  <= MASK_RESET;
    end else begin
      ctrl_word <= next_ctrl_word;
      preset_lo <= next_preset_lo;
      preset_hi <= next_preset_hi;
      irq_mask  <= next_irq_mask;
    end
  end

  // trigger, inhibit and clear bits of the control word
  assign ctrl = '{trig:     ctrl_word[BIT_TRIG],      // see [R7]
                  inhibit:  ctrl_word[BIT_INHIBIT],   // see [R8]
                  done_clr: ctrl_word[BIT_DONE_CLR]}; // see [R8]

  // ----------------------------------------------------------------
  // sync logic and counter
  // ----------------------------------------------------------------
  logic        armed;
  logic        trig_q;
  logic        enc_q;
  logic        sync_done;
  logic [31:0] count;
  logic        trig_rise;
  logic        enc_rise;
  logic        do_load;
  logic        next_trig_q;
  logic        next_enc_q;
  logic        next_sync_done;
  logic [31:0] next_count;

  assign armed     = !ctrl.inhibit && !flt_level && !ctrl.done_clr; // see [R2]
  assign trig_rise = ctrl.trig && !trig_q;
  assign enc_rise  = enc_level && !enc_q;
  assign do_load   = armed && trig_rise;                          // see [R3]

  always_comb begin
    next_trig_q    = ctrl.trig;
    next_enc_q     = enc_level;
    next_sync_done = sync_done;
    next_count     = count;
    if (do_load) begin
      next_count = {preset_hi, preset_lo};                      // see [R3]
    end else if (enc_rise) begin
      next_count = count + 32'h0000_0001;                       // see [R1]
    end
    // set wins over the clear
    if (ctrl.done_clr) begin
      next_sync_done = 1'b0;                                    // see [R5]
    end
    if (do_load) begin
      next_sync_done = 1'b1;                                    // see [R4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trig_q    <= 1'b0;
      enc_q     <= 1'b0;
      sync_done <= 1'b0;
      count     <= COUNT_RESET;
    end else begin
      trig_q    <= next_trig_q;
      enc_q     <= next_enc_q;
      sync_done <= next_sync_done;
      count     <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] irq_evt;
  logic       next_irq;
  logic       wrap;

  assign wrap    = enc_rise && !do_load && (count == 32'hFFFF_FFFF);
  assign irq_evt = {wrap, do_load};

  always_comb begin
    next_irq_stat = irq_stat;
    if (is_wr(bus_i, ADDR_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~bus_i.wdata[1:0];
    end
    next_irq_stat = next_irq_stat | irq_evt;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o    <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  logic [15:0] status_word;

  always_comb begin
    status_word            = 16'h0000;
    status_word[BIT_DONE]  = sync_done;                          // see [R9]
    status_word[BIT_ARMED] = armed;
    status_word[BIT_FAULT] = flt_level;
    next_rdata             = 16'h0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_CTRL:     next_rdata = ctrl_word;
        ADDR_STATUS:   next_rdata = status_word;
        ADDR_CNT_LO:   next_rdata = count[15:0];                 // see [R9]
        ADDR_CNT_HI:   next_rdata = count[31:16];
        ADDR_PRE_LO:   next_rdata = preset_lo;
        ADDR_PRE_HI:   next_rdata = preset_hi;
        ADDR_IRQ_STAT: next_rdata = {14'h0000, irq_stat};
        ADDR_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
        default:       next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  preset_load_a: assert property (@(posedge clk_i) // see [R3]
    disable iff (reset_i)
    (armed && ctrl.trig && !trig_q) |=>
    (count == $past({preset_hi, preset_lo})))
    else $error("counter not loaded with preset on armed trigger");

  no_load_a: assert property (@(posedge clk_i) // see [R2]
    disable iff (reset_i)
    (ctrl.inhibit && !enc_rise) |=> (count == $past(count)))
    else $error("counter changed while inhibited");

  done_set_a: assert property (@(posedge clk_i) // see [R4]
    disable iff (reset_i)
    do_load |=> sync_done)
    else $error("done flag not set after preset");

  done_hold_a: assert property (@(posedge clk_i) // see [R4]
    disable iff (reset_i)
    (sync_done && !ctrl.done_clr) |=> sync_done)
    else $error("done flag dropped without clear");

  done_clear_a: assert property (@(posedge clk_i) // see [R5]
    disable iff (reset_i)
    (ctrl.done_clr && !do_load) |=> !sync_done)
    else $error("done flag not cleared");

  count_step_a: assert property (@(posedge clk_i) // see [R1]
    disable iff (reset_i)
    (enc_rise && !do_load) |=> (count == $past(count) + 32'h0000_0001))
    else $error("encoder pulse not counted");

  status_read_a: assert property (@(posedge clk_i) // see [R9]
    disable iff (reset_i)
    (bus_i.rd && bus_i.addr == ADDR_STATUS) |=>
    (rdata_o[BIT_DONE] == $past(sync_done)))
    else $error("status bit 5 does not show done");

  inhibit_bit_a: assert property (@(posedge clk_i) // see [R8]
    disable iff (reset_i)
    (ctrl_word[BIT_INHIBIT] || ctrl_word[BIT_DONE_CLR]) |-> !armed)
    else $error("armed while inhibit or clear set");

  // a disarmed trigger must leave the count alone, fault included
  armed_hold_a: assert property (@(posedge clk_i) // see [R2]
    disable iff (reset_i)
    (!armed && !enc_rise) |=> (count == $past(count)))
    else $error("counter changed while disarmed");

  done_source_a: assert property (@(posedge clk_i) // see [R4]
    disable iff (reset_i)
    (!do_load && !sync_done) |=> !sync_done)
    else $error("done flag set without preset");

  sync_irq_a: assert property (@(posedge clk_i) // see [R4]
    disable iff (reset_i)
    do_load |=> irq_stat[IRQ_SYNC])
    else $error("preset event not latched");

  wrap_irq_a: assert property (@(posedge clk_i) // see [R1]
    disable iff (reset_i)
    wrap |=> irq_stat[IRQ_WRAP])
    else $error("wrap event not latched");

  read_idle_a: assert property (@(posedge clk_i) // see [R9]
    disable iff (reset_i)
    !bus_i.rd |=> (rdata_o == 16'h0000))
    else $error("read data not zero outside a read");

  count_read_a: assert property (@(posedge clk_i) // see [R9]
    disable iff (reset_i)
    (bus_i.rd && bus_i.addr == ADDR_CNT_LO) |=>
    (rdata_o == $past(count[15:0])))
    else $error("count low half misread");

endmodule

// [tb/epsc_enc_model.sv]
/*
  encoder stand-in: emits n pulses, four clocks high, four clocks low.
  assumes go_i is a one-clock pulse with n_i stable beside it.
*/
module epsc_enc_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n_i,
  output logic            enc_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // spacing of eight clocks keeps above the six-clock minimum
  initial begin
    enc_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (n_i) begin
          enc_o <= 1'b1;
          repeat (4) @(posedge clk_i);
          enc_o <= 1'b0;
          repeat (4) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// [tb/encoder_position_sync_counter_tb.sv]
/*
  bench for the sync counter: table of preset cases, then hand tests.
  assumes the encoder stand-in and a 250 mhz clock.
*/
module encoder_position_sync_counter_tb
  import epsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] base;
    logic        flt;
    logic [31:0] pre;
    logic        load;
  } epsc_row_t;
  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  logic        clk_i;
  logic        reset_i;
  epsc_bus_t   bus_i;
  logic        fault_i;
  logic        enc_go;
  logic [7:0]  enc_n;
  logic        enc_pulse;
  logic        enc_busy;
  logic [15:0] rdata_o;
  logic        irq_o;
  logic [15:0] rd_val;
  logic [31:0] exp_cnt;
  logic [31:0] c;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  epsc_row_t   rows [5] = '{
    '{16'h0000, 1'b0, 32'h0001_2345, 1'b1},
    '{16'h0400, 1'b0, 32'h00AB_0000, 1'b0},
    '{16'h0800, 1'b0, 32'h0000_00CD, 1'b0},
    '{16'h0000, 1'b1, 32'h1111_2222, 1'b0},
    '{16'h0000, 1'b0, 32'hFFFF_FFFE, 1'b1}};
  epsc_counter u_dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .enc_pulse_i(enc_pulse), .fault_i(fault_i), .rdata_o(rdata_o),
    .irq_o(irq_o));
  epsc_enc_model u_enc (.clk_i(clk_i), .go_i(enc_go), .n_i(enc_n),
    .enc_o(enc_pulse), .busy_o(enc_busy));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 rd_val = rdata_o;
  endtask
  task automatic rd_cnt();
    rd(ADDR_CNT_LO);
    c[15:0] = rd_val;
    rd(ADDR_CNT_HI);
    c[31:16] = rd_val;
  endtask
  task automatic tidy();
    wr(ADDR_CTRL, 16'h0800);
    wr(ADDR_CTRL, 16'h0000);
  endtask
  task automatic sync(input logic [15:0] base);
    wr(ADDR_CTRL, base);
    wr(ADDR_CTRL, base | 16'h0200);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk_i);
    #1 check("irq", irq_o, e);
  endtask
  task automatic pulses(input logic [7:0] n);
    @(posedge clk_i);
    enc_go <= 1'b1;
    enc_n <= n;
    @(posedge clk_i);
    enc_go <= 1'b0;
    for (int i = 0; i < 400 && (enc_busy !== 1'b0 || i < 2); i++)
      @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    bus_i = '0;
    fault_i = 1'b0;
    enc_go = 1'b0;
    enc_n = 8'h00;
    reset_i = 1'b1;
    exp_cnt = 32'h0000_0000;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    // unmapped places ignore writes and read zero
    for (int a = 0; a < 16; a++) begin
      if (a > 7) wr(4'(a), 16'hFFFF);
      rd(4'(a));
      check("reset_read", rd_val, (a == 1) ? 32'h1 : 32'h0);
    end
    foreach (rows[i]) begin
      tidy();
      fault_i <= rows[i].flt;
      wr(ADDR_PRE_LO, rows[i].pre[15:0]);
      wr(ADDR_PRE_HI, rows[i].pre[31:16]);
      rd(ADDR_PRE_HI);
      check("preset_hi", rd_val, rows[i].pre[31:16]);
      rd(ADDR_STATUS);
      check("fault", rd_val[BIT_FAULT], rows[i].flt);
      sync(rows[i].base);
      if (rows[i].load) exp_cnt = rows[i].pre;
      rd_cnt();
      check("count", c, exp_cnt);
      rd(ADDR_STATUS);
      check("done", rd_val[BIT_DONE], rows[i].load);
    end
    fault_i <= 1'b0;
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_STATUS);
    check("done_held", rd_val[BIT_DONE], 1'b1);
    wr(ADDR_CTRL, 16'h0800);
    rd(ADDR_STATUS);
    check("done_clr", rd_val[BIT_DONE], 1'b0);
    // an edge seen while inhibited must not load later
    wr(ADDR_CTRL, 16'h0600);
    wr(ADDR_CTRL, 16'h0200);
    rd_cnt();
    check("consumed", c, exp_cnt);
    tidy();
    sync(16'h0C00);
    rd(ADDR_STATUS);
    check("both_set", rd_val[BIT_DONE], 1'b0);
    tidy();
    wr(ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0002);
    pulses(8'h03);
    rd_cnt();
    check("wrap_count", c, 32'h0000_0001);
    check("irq_wrap", irq_o, 1'b1);
    wr(ADDR_IRQ_MASK, 16'h0001);
    irq_is(1'b0);
    sync(16'h0000);
    irq_is(1'b1);
    wr(ADDR_IRQ_STAT, 16'h0001);
    irq_is(1'b0);
    rd(ADDR_IRQ_STAT);
    check("irq_stat", rd_val, 16'h0002);
    // leave the wrap interrupt raised so the reset has work to do
    wr(ADDR_IRQ_MASK, 16'h0003);
    irq_is(1'b1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd_cnt();
    check("mid_reset", c, 32'h0000_0000);
    check("mid_irq", irq_o, 1'b0);
    tally_and_finish();
  end
endmodule
